// *** rtl/pitc_pkg.sv ***
/*
 * pitc_pkg: constants for the prescaled interval timer/event counter.
 * assumes: the cpu core presents one-cycle command strobes on the same clock.
 */
package pitc_pkg;
    // ---------------------------------------------------------------
    // widths and values
    // ---------------------------------------------------------------
    localparam int        TIMER_W      = 8;
    localparam int        PRE_W        = 5;
    localparam logic [4:0] PRE_ZERO    = 5'h00;
    localparam logic [4:0] PRE_ALL_ONES = 5'h1f;
    localparam logic [7:0] TIMER_ZERO  = 8'h00;
    localparam logic [7:0] TIMER_MAX   = 8'hff;

    // ---------------------------------------------------------------
    // counting modes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        PITC_STOPPED = 2'b00,
        PITC_TIMING  = 2'b01,
        PITC_EVENTS  = 2'b10
    } pitc_mode_t;
endpackage : pitc_pkg

// *** rtl/pitc_timer.sv ***
/*
 * pitc_timer: 8-bit interval timer / event counter with a divide-by-32
 * prescaler, timer flag and timer interrupt request.
 * assumes: the cpu core pulses commands for one CLK cycle, pulses
 * PRESCALE_TICK once per single-cycle instruction (twice per double-cycle
 * one), and EVENT_INPUT_PIN is an asynchronous pin.
 */
// Contract
// [R1] 8-bit timer runs beside program execution
// [R2] divide-by-32 prescaler, timer mode only
// [R3] timer start clears prescaler; ticks per instruction cycle
// [R4] prescaler wrap increments main timer
// [R5] overflow sets flag, requests enabled interrupt
// [R6] branch op can test overflow flag
// [R7] branch clears flag; reset leaves flag
// [R8] timer readable and loadable; prescaler hidden
// [R9] counter mode counts rising pin edges
// [R10] modes exclusive; start selects, stop halts
// [R11] stopped timer holds value, ignores events
`timescale 1ns/1ps
`default_nettype none
module pitc_timer (
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    input  wire logic       TIMER_MODE_START_CMD,
    input  wire logic       EVENT_COUNT_START_CMD,
    input  wire logic       COUNT_HALT_CMD,
    input  wire logic       PRESCALE_TICK,
    input  wire logic       EVENT_INPUT_PIN,
    input  wire logic       OVERFLOW_FLAG_BRANCH,
    input  wire logic       TIMER_LOAD_OP,
    input  wire logic [7:0] LOAD_DATA,
    input  wire logic       TIMER_INT_ENABLE,
    output logic      [7:0] TIMER_READ_DATA,
    output logic            FLAG_TAKEN,
    output logic            TIMER_INT_REQ,
    output logic      [1:0] MODE
);
    // ---------------------------------------------------------------
    // pin synchroniser
    // ---------------------------------------------------------------
    logic sync_a;
    logic sync_b;
    logic pin_last;

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync_a   <= 1'b0;
            sync_b   <= 1'b0;
            pin_last <= 1'b0;
        end else begin
            sync_a   <= EVENT_INPUT_PIN;
            sync_b   <= sync_a;
            pin_last <= sync_b;
        end
    end

    wire pin_rise = sync_b & ~pin_last;

    // ---------------------------------------------------------------
    // mode, prescaler, timer, interrupt request
    // ---------------------------------------------------------------
    pitc_pkg::pitc_mode_t mode;
    pitc_pkg::pitc_mode_t next_mode;
    logic [4:0] pre;
    logic [4:0] next_pre;
    logic [7:0] timer;
    logic [7:0] next_timer;
    logic       irq;
    logic       next_irq;
    logic       inc;
    logic       ovf;

    always_comb begin
        next_mode = mode;
        next_pre  = pre;
        next_timer = timer;
        inc = 1'b0;
        // if several strobe at once, halt wins, then event start, then timer start
        if (COUNT_HALT_CMD) begin
            next_mode = pitc_pkg::PITC_STOPPED; // [R10]
        end else if (EVENT_COUNT_START_CMD) begin
            next_mode = pitc_pkg::PITC_EVENTS; // [R10]
        end else if (TIMER_MODE_START_CMD) begin
            next_mode = pitc_pkg::PITC_TIMING; // [R10]
            next_pre  = pitc_pkg::PRE_ZERO; // [R3]
        end
        case (mode)
            pitc_pkg::PITC_TIMING: begin
                if (PRESCALE_TICK && !TIMER_MODE_START_CMD) begin
                    next_pre = pre + 5'h01; // [R2] [R3]
                    inc = (pre == pitc_pkg::PRE_ALL_ONES); // [R4]
                end
            end
            pitc_pkg::PITC_EVENTS: begin
                inc = pin_rise; // [R9]
            end
            pitc_pkg::PITC_STOPPED: begin
                inc = 1'b0; // [R11]
            end
            default: begin
                inc = 1'b0;
            end
        endcase
        ovf = inc && (timer == pitc_pkg::TIMER_MAX);
        if (TIMER_LOAD_OP) begin
            // a load overrides a coincident increment
            next_timer = LOAD_DATA; // [R8]
        end else if (inc) begin
            next_timer = timer + 8'h01; // [R1]
        end
        next_irq = ovf && TIMER_INT_ENABLE && !TIMER_LOAD_OP; // [R5]
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mode  <= pitc_pkg::PITC_STOPPED;
            pre   <= pitc_pkg::PRE_ZERO;
            timer <= pitc_pkg::TIMER_ZERO;
            irq   <= 1'b0;
        end else begin
            mode  <= next_mode;
            pre   <= next_pre;
            timer <= next_timer;
            irq   <= next_irq;
        end
    end

    // ---------------------------------------------------------------
    // timer flag: deliberately outside the reset, so reset leaves it
    // ---------------------------------------------------------------
    logic flag = 1'b0;
    logic next_flag;
    logic taken;
    logic next_taken;

    always_comb begin
        next_taken = OVERFLOW_FLAG_BRANCH & flag; // [R6]
        next_flag  = flag;
        if (OVERFLOW_FLAG_BRANCH) begin
            next_flag = 1'b0; // [R7]
        end
        if (ovf && !TIMER_LOAD_OP) begin
            next_flag = 1'b1; // [R5]
        end
    end

    always_ff @(posedge CLK) begin
        flag  <= next_flag; // [R7]
        taken <= next_taken;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign TIMER_READ_DATA = timer; // [R8]
    assign FLAG_TAKEN      = taken;
    assign TIMER_INT_REQ   = irq;
    assign MODE            = mode;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    wrap_increments_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R4]
        (mode == pitc_pkg::PITC_TIMING && PRESCALE_TICK && pre == pitc_pkg::PRE_ALL_ONES
         && !TIMER_MODE_START_CMD && !TIMER_LOAD_OP && !COUNT_HALT_CMD)
        |=> TIMER_READ_DATA == $past(timer) + 8'h01)
        else $error("prescaler wrap did not step timer");

    start_clears_pre_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R3]
        (TIMER_MODE_START_CMD && !COUNT_HALT_CMD && !EVENT_COUNT_START_CMD)
        |=> pre == pitc_pkg::PRE_ZERO && mode == pitc_pkg::PITC_TIMING)
        else $error("timer start left prescaler uncleared");

    overflow_flag_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R5]
        (ovf && !TIMER_LOAD_OP) |=> flag && TIMER_READ_DATA == pitc_pkg::TIMER_ZERO)
        else $error("overflow did not set flag");

    irq_gated_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R5]
        TIMER_INT_REQ |-> $past(TIMER_INT_ENABLE) && $past(ovf))
        else $error("interrupt without enabled overflow");

    branch_clears_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R7]
        (OVERFLOW_FLAG_BRANCH && !ovf) |=> !flag)
        else $error("branch left flag set");

    branch_taken_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R6]
        OVERFLOW_FLAG_BRANCH |=> FLAG_TAKEN == $past(flag))
        else $error("branch answer wrong");

    load_timer_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R8]
        TIMER_LOAD_OP |=> TIMER_READ_DATA == $past(LOAD_DATA))
        else $error("timer load lost");

    pin_edge_count_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R9]
        (mode == pitc_pkg::PITC_EVENTS && pin_rise && !TIMER_LOAD_OP)
        |=> TIMER_READ_DATA == $past(timer) + 8'h01)
        else $error("rising edge not counted");

    stopped_holds_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R11]
        (mode == pitc_pkg::PITC_STOPPED && !TIMER_LOAD_OP) |=> $stable(TIMER_READ_DATA))
        else $error("stopped timer moved");

    halt_stops_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R10]
        COUNT_HALT_CMD |=> mode == pitc_pkg::PITC_STOPPED)
        else $error("halt did not stop");

    irq_raised_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R5]
        (ovf && TIMER_INT_ENABLE && !TIMER_LOAD_OP) |=> TIMER_INT_REQ)
        else $error("enabled overflow raised no interrupt");

    event_start_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R10]
        (EVENT_COUNT_START_CMD && !COUNT_HALT_CMD) |=> mode == pitc_pkg::PITC_EVENTS)
        else $error("event start did not select counting");

    // ticks must not leak into event counting: the prescaler is timer-only
    event_idle_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R2]
        (mode == pitc_pkg::PITC_EVENTS && !pin_rise && !TIMER_LOAD_OP)
        |=> TIMER_READ_DATA == $past(timer))
        else $error("event mode moved without an edge");

    // no disable here on purpose: the flag must ride through reset untouched
    flag_holds_a: assert property (@(posedge CLK) // [R7]
        (!OVERFLOW_FLAG_BRANCH && !(ovf && !TIMER_LOAD_OP)) |=> flag == $past(flag))
        else $error("flag changed without branch or overflow");
endmodule : pitc_timer
`default_nettype wire

// *** bench/pitc_evt_src.sv ***
/*
 * pitc_evt_src: far-side source of event edges on the counter pin.
 * assumes: one CLK shared with the timer; fire is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module pitc_evt_src (
    input  wire logic CLK,
    input  wire logic SYS_RST,
    input  wire logic FIRE,
    output logic      PIN
);
    // ---------------------------------------------------------------
    // one rising edge per fire, then a quiet gap
    // ---------------------------------------------------------------
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    // a busy source ignores fire so edges never crowd together
    always_comb begin
        next_cnt = (cnt != 4'h0) ? cnt - 4'h1 : (FIRE ? 4'hf : 4'h0);
    end
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cnt <= 4'h0;
        end else begin
            cnt <= next_cnt;
        end
    end
    assign PIN = cnt[3];
endmodule : pitc_evt_src
`default_nettype wire

// *** bench/tb_top.sv ***
/*
 * tb_top: directed tests of the interval timer through command pulses.
 * assumes: commands are one-cycle strobes; pin edges come from pitc_evt_src.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [5:0] cmd = 6'h00;
    logic       fire = 1'b0;
    logic       pin;
    logic [7:0] ld = 8'h00;
    logic       ien = 1'b1;
    logic [7:0] rd;
    logic       ft;
    logic       irq;
    logic [1:0] mode;
    logic [7:0] fv;
    int         errors = 0;
    int         tests_run = 0;
    int         irqs = 0;
    initial forever #25 clk = ~clk;
    pitc_timer i_dut (.CLK(clk), .SYS_RST(sys_rst), .TIMER_MODE_START_CMD(cmd[0]),
        .EVENT_COUNT_START_CMD(cmd[1]), .COUNT_HALT_CMD(cmd[2]), .PRESCALE_TICK(cmd[3]),
        .EVENT_INPUT_PIN(pin), .OVERFLOW_FLAG_BRANCH(cmd[4]), .TIMER_LOAD_OP(cmd[5]),
        .LOAD_DATA(ld), .TIMER_INT_ENABLE(ien), .TIMER_READ_DATA(rd), .FLAG_TAKEN(ft),
        .TIMER_INT_REQ(irq), .MODE(mode));
    pitc_evt_src i_src (.CLK(clk), .SYS_RST(sys_rst), .FIRE(fire), .PIN(pin));
    always @(posedge clk) if (irq === 1'b1) irqs++;
    // ---------------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------------
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic op(input logic [5:0] c);
        cmd = c;
        @(posedge clk);
        #5 cmd = 6'h00;
        @(posedge clk);
        #5;
    endtask : op
    // the branch answer stands for one cycle only, so it is caught right after the edge
    task automatic branch(output logic [7:0] f);
        cmd = 6'h10;
        @(posedge clk);
        #5 cmd = 6'h00;
        f = {7'h00, ft};
        @(posedge clk);
        #5;
    endtask : branch
    task automatic ticks(input int n);
        repeat (n) op(6'h08);
    endtask : ticks
    task automatic edges(input int n);
        repeat (n) begin
            fire = 1'b1;
            @(posedge clk);
            #5 fire = 1'b0;
            repeat (18) @(posedge clk);
            #5;
        end
    endtask : edges
    task automatic end_of_test;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        #200us;
        errors++;
        end_of_test;
    end
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        #5 sys_rst = 1'b0;
        op(6'h10);
        check("mode", 8'h00, {6'h00, mode});
        ld = 8'hfe;
        op(6'h20);
        check("load", 8'hfe, rd);
        op(6'h01);
        check("mode", 8'h01, {6'h00, mode});
        ticks(20);
        op(6'h01);
        ticks(31);
        check("clr", 8'hfe, rd);
        ticks(1);
        check("step", 8'hff, rd);
        ticks(32);
        check("wrap", 8'h00, rd);
        check("irq", 8'h01, irqs[7:0]);
        branch(fv);
        check("flag", 8'h01, fv);
        branch(fv);
        check("flag", 8'h00, fv);
        op(6'h04);
        ticks(40);
        edges(1);
        check("hold", 8'h00, rd);
        op(6'h02);
        check("mode", 8'h02, {6'h00, mode});
        edges(3);
        ticks(40);
        check("events", 8'h03, rd);
        ien = 1'b0;
        ld = 8'hff;
        op(6'h20);
        edges(1);
        check("irqoff", 8'h01, irqs[7:0]);
        sys_rst = 1'b1;
        @(posedge clk);
        #5 sys_rst = 1'b0;
        check("rstmode", 8'h00, {6'h00, mode});
        branch(fv);
        check("keep", 8'h01, fv);
        end_of_test;
    end
endmodule : tb_top
`default_nettype wire
